/* File: sim/afb_fabric_model.sv */
// Peer peripheral that masters analog bus halves
`timescale 1ns/1ps
`default_nettype none
module afb_fabric_model
    import afb_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [HALF_N-1:0]      own,
    input  wire logic [HALF_N*CH_W-1:0] ch_set,
    output var  logic [HALF_N*CH_W-1:0] fabric_ch
);
    logic [CH_W-1:0] spin_q = 5'h00;

    always_ff @(posedge clk)
    begin
        spin_q <= spin_q + 5'h01;
    end

    // Mastered halves carry peer channel, others churn
    always_comb
    begin
        for (int h = 0; h < HALF_N; h++)
        begin
            fabric_ch[h*CH_W +: CH_W] = own[h] ? ch_set[h*CH_W +: CH_W] : spin_q ^ CH_W'(h);
        end
    end
endmodule : afb_fabric_model
`default_nettype wire

/* File: sim/test_adc_fifo_flush_and_bus_master_ctl.sv */
// Self-checking bench for queue flush and bus master control
`timescale 1ns/1ps
`default_nettype none
module test_adc_fifo_flush_and_bus_master_ctl
    import afb_pkg::*;
();
    logic                   clk   = 1'b0;
    logic                   rst   = 1'b1;
    logic [ADDR_W-1:0]      adr   = 8'h00;
    logic                   rd    = 1'b0;
    logic                   wr    = 1'b0;
    logic [DATA_W-1:0]      wdat  = 32'h0;
    logic [3:0]             be    = 4'hf;
    logic [DATA_W-1:0]      rdata;
    logic                   waitreq;
    afb_res_type            sres  = '0;
    afb_res_type            cres  = '0;
    afb_sel_type            psel  = '0;
    afb_sel_type            nsel  = '0;
    afb_sel_type            ssel  = '0;
    logic [HALF_N-1:0]      own   = 8'h00;
    logic [HALF_N*CH_W-1:0] chs   = '0;
    logic [HALF_N*CH_W-1:0] fab;
    logic [HALF_N-1:0]      req;
    logic [HALF_N*CH_W-1:0] dch;
    logic [CH_W-1:0]        pch;
    logic [CH_W-1:0]        nch;
    logic [CH_W-1:0]        sch;
    logic [DATA_W-1:0]      r;
    logic [DATA_W-1:0]      w;
    logic [CH_W-1:0]        c;
    logic [CH_W-1:0]        pc;
    logic [RES_W-1:0]       v;
    int                     n;
    int                     n_mismatch = 0;
    int                     n_compared = 0;

    afb_ctl afb_ctl_i (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .single_res(sres), .scan_res(cres), .positive_input_choice(psel), .negative_input_choice(nsel),
        .scan_input_choice(ssel), .fabric_ch(fab), .bus_req(req), .bus_drive_ch(dch),
        .pos_ch(pch), .neg_ch(nch), .scan_ch(sch));

    afb_fabric_model afb_fabric_model_i (.clk(clk), .own(own), .ch_set(chs), .fabric_ch(fab));

    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic end_of_test();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Status or passive bit of one bus half
    function automatic logic [DATA_W-1:0] half_bit(input int h);
        half_bit = 32'h4 << h;
    endfunction : half_bit

    // One Avalon access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wt, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
        @(posedge clk);
        rd   <= !wt;
        wr   <= wt;
        adr  <= a;
        wdat <= d;
        @(posedge clk);
        while (waitreq !== 1'b0)
            @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic push(input int q, input logic [RES_W-1:0] d);
        @(posedge clk);
        if (q == 1)
            cres <= '{1'b1, d};
        else
            sres <= '{1'b1, d};
        @(posedge clk);
        cres.push <= 1'b0;
        sres.push <= 1'b0;
    endtask : push

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(13));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, OFS_PASSIVE, '0, r);
        chk("passive reset", 32'h0, r);
        for (int i = 0; i < 6; i++)
        begin
            w = $urandom & 32'h3fc;
            bus(1'b1, OFS_PASSIVE, w, r);
            bus(1'b0, OFS_PASSIVE, '0, r);
            chk("passive rw", w, r);
        end
        bus(1'b0, 8'hfc, '0, r);
        chk("unmapped", 32'h0, r);
        // Queue 0 single, queue 1 scan; scan is overfilled
        for (int q = 0; q < 2; q++)
        begin
            n = (q == 1) ? 5 : 1 + $urandom % 3;
            for (int k = 0; k < n; k++)
                push(q, RES_W'($urandom));
            if (n > Q_DEPTH)
                n = Q_DEPTH;
            be <= 4'he;
            bus(1'b1, q ? OFS_SCAN_FLUSH : OFS_SGL_FLUSH, 32'h1, r);
            be <= 4'hf;
            bus(1'b1, q ? OFS_SCAN_FLUSH : OFS_SGL_FLUSH, 32'hfffffffe, r);
            bus(1'b0, q ? OFS_SCAN_CNT : OFS_SGL_CNT, '0, r);
            chk("count kept", n, r & 32'h7);
            bus(1'b1, q ? OFS_SCAN_FLUSH : OFS_SGL_FLUSH, 32'h1, r);
            bus(1'b0, q ? OFS_SCAN_CNT : OFS_SGL_CNT, '0, r);
            chk("count flushed", 32'h0, r & 32'h7);
            v = RES_W'($urandom);
            push(q, v);
            bus(1'b0, q ? OFS_SCAN_DATA : OFS_SGL_DATA, '0, r);
            chk("first after flush", v, r & 32'hffff);
        end
        // Each half mastered, then monitored passively
        for (int h = 0; h < HALF_N; h++)
        begin
            c  = CH_W'($urandom);
            pc = CH_W'($urandom);
            bus(1'b1, OFS_PASSIVE, 32'h0, r);
            own <= 8'h00;
            chs[h*CH_W +: CH_W] <= pc;
            psel <= '{h % 3 == 0, 3'(h), c};
            nsel <= '{h % 3 == 1, 3'(h), c};
            ssel <= '{h % 3 == 2, 3'(h), c};
            repeat (5) @(posedge clk);
            chk("req", 8'h01 << h, req);
            chk("drive", c, dch[h*CH_W +: CH_W]);
            chk("own ch", c, h % 3 == 0 ? pch : h % 3 == 1 ? nch : sch);
            bus(1'b0, OFS_BUS_REQ, '0, r);
            chk("req status", half_bit(h), r);
            bus(1'b1, OFS_PASSIVE, half_bit(h), r);
            own <= 8'h01 << h;
            repeat (6) @(posedge clk);
            chk("no req", 32'h0, req);
            chk("no drive", 32'h0, dch[h*CH_W +: CH_W]);
            chk("follow", pc, h % 3 == 0 ? pch : h % 3 == 1 ? nch : sch);
        end
        // Second reset clears the passive bits
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, OFS_PASSIVE, '0, r);
        chk("passive rereset", 32'h0, r);
        end_of_test();
    end
endmodule : test_adc_fifo_flush_and_bus_master_ctl
`default_nettype wire

/* File: verilog/afb_bus_half.sv */
// One analog bus half: request, channel drive and passive follow
`timescale 1ns/1ps
`default_nettype none
module afb_bus_half
    import afb_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            passive,
    input  wire logic            hit,
    input  wire logic [CH_W-1:0] own_ch,
    input  wire logic [CH_W-1:0] fabric_ch,
    output var  logic            req,
    output var  logic [CH_W-1:0] drive_ch,
    output var  logic [CH_W-1:0] follow_ch
);
    logic [CH_W-1:0] sync1_q;
    logic [CH_W-1:0] sync2_q;
    logic            req_q;
    logic [CH_W-1:0] drive_q;

    assign req       = req_q;
    assign drive_ch  = drive_q;
    assign follow_ch = sync2_q;

    // Master channel from the fabric, two stages
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= CH_RST;
            sync2_q <= CH_RST;
        end
        else
        begin
            sync1_q <= fabric_ch;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            req_q   <= 1'b0;
            drive_q <= CH_RST;
        end
        else
        begin
            req_q   <= hit && !passive;
            drive_q <= (hit && !passive) ? own_ch : CH_RST;
        end
    end

    a_passive_no_req: assert property (@(posedge clk) disable iff (rst)
        passive |=> !req_q)
        else $error("passive half raised a request");
    a_active_req: assert property (@(posedge clk) disable iff (rst)
        (hit && !passive) |=> req_q && (drive_q == $past(own_ch)))
        else $error("active half did not request or drive");
    a_follow_lag: assert property (@(posedge clk) disable iff (rst)
        ##2 1 |-> sync2_q == $past(fabric_ch, 2))
        else $error("followed channel not two cycles behind");
endmodule : afb_bus_half
`default_nettype wire

/* File: verilog/afb_ctl.sv */
// Register bank for queue flush and analog bus master control
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module afb_ctl
    import afb_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [ADDR_W-1:0]        avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [DATA_W-1:0]        avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output var  logic [DATA_W-1:0]        avs_readdata,
    output var  logic                     avs_waitrequest,
    input  wire afb_res_type              single_res,
    input  wire afb_res_type              scan_res,
    input  wire afb_sel_type              positive_input_choice,
    input  wire afb_sel_type              negative_input_choice,
    input  wire afb_sel_type              scan_input_choice,
    input  wire logic [HALF_N*CH_W-1:0]   fabric_ch,
    output var  logic [HALF_N-1:0]        bus_req,
    output var  logic [HALF_N*CH_W-1:0]   bus_drive_ch,
    output var  logic [CH_W-1:0]          pos_ch,
    output var  logic [CH_W-1:0]          neg_ch,
    output var  logic [CH_W-1:0]          scan_ch
);
    logic                    wait_q;
    logic [DATA_W-1:0]       rdata_q;
    logic [HALF_N-1:0]       passive_q;
    logic [CH_W-1:0]         pos_ch_q;
    logic [CH_W-1:0]         neg_ch_q;
    logic [CH_W-1:0]         scan_ch_q;
    logic                    wr_done;
    logic                    rd_take;
    logic                    rd_done;
    logic                    sgl_flush;
    logic                    scan_flush;
    logic [CNT_W-1:0]        sgl_cnt;
    logic [CNT_W-1:0]        scan_cnt;
    logic [RES_W-1:0]        sgl_head;
    logic [RES_W-1:0]        scan_head;
    logic [HALF_N-1:0]       half_hit;
    logic [HALF_N-1:0]       half_req;
    logic [HALF_N*CH_W-1:0]  own_ch;
    logic [HALF_N*CH_W-1:0]  follow_ch;
    logic [DATA_W-1:0]       rdata_d;

    // Bus handshake: one wait cycle, then completion
    assign wr_done = avs_write && !wait_q;
    assign rd_take = avs_read && wait_q;
    assign rd_done = avs_read && !wait_q;

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;
    assign pos_ch          = pos_ch_q;
    assign neg_ch          = neg_ch_q;
    assign scan_ch         = scan_ch_q;
    assign bus_req         = half_req;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end

    // Flush strobes, only a one in bit 0 counts
    assign sgl_flush  = wr_done && (avs_address == OFS_SGL_FLUSH) && avs_byteenable[0]
                        && avs_writedata[FLUSH_BIT];
    assign scan_flush = wr_done && (avs_address == OFS_SCAN_FLUSH) && avs_byteenable[0]
                        && avs_writedata[FLUSH_BIT];

    // Passive bits, reserved bits dropped
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            passive_q <= PASSIVE_RST;
        end
        else if (wr_done && (avs_address == OFS_PASSIVE))
        begin
            if (avs_byteenable[0])
            begin
                passive_q[5:0] <= avs_writedata[7:PASSIVE_LSB];
            end
            if (avs_byteenable[1])
            begin
                passive_q[7:6] <= avs_writedata[PASSIVE_MSB:8];
            end
        end
    end

    always_comb
    begin
        rdata_d = '0;
        case (avs_address)
            OFS_PASSIVE:   rdata_d[PASSIVE_MSB:PASSIVE_LSB] = passive_q;
            OFS_BUS_REQ:   rdata_d[PASSIVE_MSB:PASSIVE_LSB] = half_req;
            OFS_SGL_CNT:   rdata_d[CNT_W-1:0] = sgl_cnt;
            OFS_SCAN_CNT:  rdata_d[CNT_W-1:0] = scan_cnt;
            OFS_SGL_DATA:  rdata_d[RES_W-1:0] = sgl_head;
            OFS_SCAN_DATA: rdata_d[RES_W-1:0] = scan_head;
            default:       rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
        end
        else if (rd_take)
        begin
            rdata_q <= rdata_d;
        end
    end

    afb_queue u_single_q (
        .clk   (clk),
        .rst   (rst),
        .res   (single_res),
        .pop   (rd_done && (avs_address == OFS_SGL_DATA)),
        .flush (sgl_flush),
        .count (sgl_cnt),
        .head  (sgl_head)
    );

    afb_queue u_scan_q (
        .clk   (clk),
        .rst   (rst),
        .res   (scan_res),
        .pop   (rd_done && (avs_address == OFS_SCAN_DATA)),
        .flush (scan_flush),
        .count (scan_cnt),
        .head  (scan_head)
    );

    // Which halves the input choices land on; positive is applied last and wins
    always_comb
    begin
        half_hit = '0;
        own_ch   = '0;
        for (int i = 0; i < HALF_N; i++)
        begin
            if (scan_input_choice.valid && (scan_input_choice.half == 3'(i)))
            begin
                half_hit[i]               = 1'b1;
                own_ch[i*CH_W +: CH_W]    = scan_input_choice.ch;
            end
            if (negative_input_choice.valid && (negative_input_choice.half == 3'(i)))
            begin
                half_hit[i]               = 1'b1;
                own_ch[i*CH_W +: CH_W]    = negative_input_choice.ch;
            end
            if (positive_input_choice.valid && (positive_input_choice.half == 3'(i)))
            begin
                half_hit[i]               = 1'b1;
                own_ch[i*CH_W +: CH_W]    = positive_input_choice.ch;
            end
        end
    end

    for (genvar g = 0; g < HALF_N; g++)
    begin : g_half
        afb_bus_half u_half (
            .clk       (clk),
            .rst       (rst),
            .passive   (passive_q[g]),
            .hit       (half_hit[g]),
            .own_ch    (own_ch[g*CH_W +: CH_W]),
            .fabric_ch (fabric_ch[g*CH_W +: CH_W]),
            .req       (half_req[g]),
            .drive_ch  (bus_drive_ch[g*CH_W +: CH_W]),
            .follow_ch (follow_ch[g*CH_W +: CH_W])
        );
    end

    // Channel the converter really uses: own or the bus master's
    function automatic logic [CH_W-1:0] eff_ch(input afb_sel_type s, input logic [HALF_N-1:0] pas,
                                               input logic [HALF_N*CH_W-1:0] fol);
        eff_ch = s.ch;
        if (s.valid && pas[s.half])
        begin
            eff_ch = fol[s.half*CH_W +: CH_W];
        end
    endfunction : eff_ch

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pos_ch_q  <= CH_RST;
            neg_ch_q  <= CH_RST;
            scan_ch_q <= CH_RST;
        end
        else
        begin
            pos_ch_q  <= eff_ch(positive_input_choice, passive_q, follow_ch);
            neg_ch_q  <= eff_ch(negative_input_choice, passive_q, follow_ch);
            scan_ch_q <= eff_ch(scan_input_choice, passive_q, follow_ch);
        end
    end

    a_wait_one_cycle: assert property (@(posedge clk) disable iff (rst)
        ((avs_read || avs_write) && wait_q) |=> !wait_q ##1 wait_q)
        else $error("waitrequest not low for exactly one cycle");
    a_sgl_flush_cnt: assert property (@(posedge clk) disable iff (rst)
        sgl_flush |=> sgl_cnt == '0)
        else $error("single count not zero after flush");
    a_scan_flush_cnt: assert property (@(posedge clk) disable iff (rst)
        scan_flush |=> scan_cnt == '0)
        else $error("scan count not zero after flush");
    a_zero_no_flush: assert property (@(posedge clk) disable iff (rst)
        (wr_done && (avs_address == OFS_SCAN_FLUSH) && !avs_writedata[FLUSH_BIT]) |-> !scan_flush)
        else $error("zero write flushed scan queue");
    a_passive_write: assert property (@(posedge clk) disable iff (rst)
        (wr_done && (avs_address == OFS_PASSIVE) && (avs_byteenable[1:0] == 2'b11))
        |=> passive_q == $past(avs_writedata[PASSIVE_MSB:PASSIVE_LSB]))
        else $error("passive bits did not take write");
    a_passive_follow: assert property (@(posedge clk) disable iff (rst)
        (positive_input_choice.valid && passive_q[positive_input_choice.half])
        |=> pos_ch_q == $past(follow_ch[positive_input_choice.half*CH_W +: CH_W]))
        else $error("passive positive channel not from bus master");
    a_sgl_zero_keep: assert property (@(posedge clk) disable iff (rst)
        (wr_done && (avs_address == OFS_SGL_FLUSH) && !avs_writedata[FLUSH_BIT])
        |=> sgl_cnt >= $past(sgl_cnt))
        else $error("zero write lowered single count");
    a_scan_zero_keep: assert property (@(posedge clk) disable iff (rst)
        (wr_done && (avs_address == OFS_SCAN_FLUSH) && !avs_writedata[FLUSH_BIT])
        |=> scan_cnt >= $past(scan_cnt))
        else $error("zero write lowered scan count");
    a_passive_silent: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (half_req & $past(passive_q)) == '0)
        else $error("passive half still requested");
    a_active_own: assert property (@(posedge clk) disable iff (rst)
        (positive_input_choice.valid && !passive_q[positive_input_choice.half])
        |=> pos_ch_q == $past(positive_input_choice.ch))
        else $error("active positive channel not own choice");
    a_req_status: assert property (@(posedge clk) disable iff (rst)
        (rd_take && (avs_address == OFS_BUS_REQ))
        |=> avs_readdata[PASSIVE_MSB:PASSIVE_LSB] == $past(half_req))
        else $error("request status read wrong");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (rd_take && (avs_address == OFS_PASSIVE))
        |=> (avs_readdata[DATA_W-1:PASSIVE_MSB+1] == '0) && (avs_readdata[PASSIVE_LSB-1:0] == '0))
        else $error("reserved passive bits read nonzero");
endmodule : afb_ctl
`default_nettype wire

/* File: verilog/afb_pkg.sv */
// Constants and types for the converter queue flush and analog bus master control
// How it works
// - Writing one to single flush bit 0 empties the single result queue; zero does nothing.
// - Writing one to scan flush bit 0 at 0x090 empties the scan queue.
// - Register 0x094 bits 9..2 hold per-half passive bits 4Y..1X, reset zero.
// - Active half: converter requests bus when any choice hits it, drives channel.
// - Passive half: no request, own channel choice ignored, monitor only.
// - Many peripherals may monitor one bus; one masters, others stay passive.
package afb_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          RES_W         = 16;
    localparam int          CH_W          = 5;
    localparam int          HALF_N        = 8;
    localparam int          Q_DEPTH       = 4;
    localparam int          CNT_W         = 3;
    localparam int          PTR_W         = 2;
    localparam logic [7:0]  OFS_SCAN_DATA = 8'h68;
    localparam logic [7:0]  OFS_BUS_REQ   = 8'h7c;
    localparam logic [7:0]  OFS_SGL_CNT   = 8'h84;
    localparam logic [7:0]  OFS_SCAN_CNT  = 8'h88;
    localparam logic [7:0]  OFS_SGL_FLUSH = 8'h8c;
    localparam logic [7:0]  OFS_SCAN_FLUSH = 8'h90;
    localparam logic [7:0]  OFS_PASSIVE   = 8'h94;
    localparam logic [7:0]  OFS_SGL_DATA  = 8'ha0;
    localparam int          FLUSH_BIT     = 0;
    localparam int          PASSIVE_LSB   = 2;
    localparam int          PASSIVE_MSB   = 9;
    localparam logic [7:0]  PASSIVE_RST   = 8'h00;
    localparam logic [4:0]  CH_RST        = 5'h00;

    typedef struct packed {
        logic            valid;
        logic [2:0]      half;
        logic [CH_W-1:0] ch;
    } afb_sel_type;

    typedef struct packed {
        logic             push;
        logic [RES_W-1:0] data;
    } afb_res_type;
endpackage : afb_pkg

/* File: verilog/afb_queue.sv */
// Result queue with flush, pop and unread count
`timescale 1ns/1ps
`default_nettype none
module afb_queue
    import afb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire afb_res_type      res,
    input  wire logic             pop,
    input  wire logic             flush,
    output var  logic [CNT_W-1:0] count,
    output var  logic [RES_W-1:0] head
);
    logic [RES_W-1:0] mem [Q_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] cnt_q;
    logic             do_push;
    logic             do_pop;

    // Full queue drops new results; empty queue ignores pops
    assign do_push = res.push && (cnt_q != CNT_W'(Q_DEPTH)) && !flush;
    assign do_pop  = pop && (cnt_q != '0) && !flush;
    assign count   = cnt_q;
    assign head    = mem[rd_ptr_q];

    always_ff @(posedge clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr_q] <= res.data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else if (flush)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_q <= wr_ptr_q + PTR_W'(1);
            end
            if (do_pop)
            begin
                rd_ptr_q <= rd_ptr_q + PTR_W'(1);
            end
            cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    a_flush_empties: assert property (@(posedge clk) disable iff (rst)
        flush |=> (cnt_q == '0) && (rd_ptr_q == '0) && (wr_ptr_q == '0))
        else $error("queue not empty after flush");
    a_count_bounded: assert property (@(posedge clk) disable iff (rst)
        cnt_q <= CNT_W'(Q_DEPTH))
        else $error("queue count over depth");
    a_push_counts: assert property (@(posedge clk) disable iff (rst)
        (do_push && !do_pop) |=> cnt_q == $past(cnt_q) + CNT_W'(1))
        else $error("push did not raise count");
endmodule : afb_queue
`default_nettype wire
